// >>> rtl/ccr_pkg.sv
// Function
// (R1) Two-bit input selector in config bits 1:0; 00 normal pair, 01 shorted.
// (R2) Selector 10 applies positive dc test signal, 11 negative dc test signal.
// (R3) Offset value bits 23:8 sit in all 16 bits of upper offset register.
// (R4) Offset bits 7:0 in upper byte of lower offset register; low byte zero.
// (R5) Offset is signed two's complement and resets to zero.
// (R6) Gain value bits 23:8 sit in all 16 bits of upper gain register.
// (R7) Gain bits 7:0 in upper byte of lower gain register; low byte zero.
// (R8) Gain is unsigned fraction from 0.0 to just under 2.0.
// (R9) Upper gain resets to 8000, lower to zero: gain of exactly one.
// (R10) Configuration register resets to zero: normal differential input.
// (R11) Writable reserved bits written as zero; read-only reserved read zero.
// (R12) Result corrected by subtracting offset then multiplying gain, saturated.
package ccr_pkg;
   // ***************************************************************
   // Register indices (byte address is four times the index)
   // ***************************************************************
   localparam logic [7:0]  IDX_CFG      = 8'h09;
   localparam logic [7:0]  IDX_OCAL_HI  = 8'h0A;
   localparam logic [7:0]  IDX_OCAL_LO  = 8'h0B;
   localparam logic [7:0]  IDX_GCAL_HI  = 8'h0C;
   localparam logic [7:0]  IDX_GCAL_LO  = 8'h0D;
   // ***************************************************************
   // Reset values and masks
   // ***************************************************************
   localparam logic [15:0] RST_CFG      = 16'h0000;
   localparam logic [15:0] RST_OCAL_HI  = 16'h0000;
   localparam logic [15:0] RST_OCAL_LO  = 16'h0000;
   localparam logic [15:0] RST_GCAL_HI  = 16'h8000;
   localparam logic [15:0] RST_GCAL_LO  = 16'h0000;
   localparam logic [15:0] MASK_CFG     = 16'hFFC7;
   localparam logic [15:0] MASK_LO      = 16'hFF00;
   localparam logic [1:0]  RESP_OKAY    = 2'b00;
   localparam logic [1:0]  RESP_SLVERR  = 2'b10;
   // ***************************************************************
   // Input selector codes
   // ***************************************************************
   localparam logic [1:0]  SEL_NORMAL   = 2'b00;
   localparam logic [1:0]  SEL_SHORT    = 2'b01;
   localparam logic [1:0]  SEL_TEST_POS = 2'b10;
   localparam logic [1:0]  SEL_TEST_NEG = 2'b11;
endpackage : ccr_pkg

// >>> rtl/ccr_regs.sv
`timescale 1ns/1ps
module ccr_regs (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // AXI4-Lite write address
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Conversion datapath
   input  wire logic [23:0] raw_sample,
   input  wire logic        raw_valid,
   output logic [23:0]      cal_sample,
   output logic             cal_valid,
   // Analog front end control
   output logic             ch0_route_inputs,
   output logic             ch0_short_inputs,
   output logic             ch0_test_pos,
   output logic             ch0_test_neg
);
   // ***************************************************************
   // Register storage
   // ***************************************************************
   logic [15:0] cfg;
   logic [15:0] ch0_offset_cal_high;
   logic [7:0]  ch0_offset_cal_low;
   logic [15:0] ch0_gain_cal_high;
   logic [7:0]  ch0_gain_cal_low;
   logic        aw_held;
   logic        w_held;
   logic [7:0]  aw_idx;
   logic [31:0] w_data;
   logic [3:0]  w_strb;

   // ***************************************************************
   // Write channel: address and data accepted in either order
   // ***************************************************************
   wire         aw_take  = s_axi_awvalid & s_axi_awready;
   wire         w_take   = s_axi_wvalid & s_axi_wready;
   wire         have_aw  = aw_held | aw_take;
   wire         have_w   = w_held | w_take;
   wire         do_write = have_aw & have_w & ~s_axi_bvalid;
   wire [7:0]   wr_idx   = aw_held ? aw_idx : s_axi_awaddr[9:2];
   wire [31:0]  wr_data  = w_held ? w_data : s_axi_wdata;
   wire [3:0]   wr_strb  = w_held ? w_strb : s_axi_wstrb;
   wire [15:0]  bmask    = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
   wire         wr_hit   = (wr_idx >= ccr_pkg::IDX_CFG) &&
                           (wr_idx <= ccr_pkg::IDX_GCAL_LO);
   wire         wr_cfg   = do_write && wr_idx == ccr_pkg::IDX_CFG;
   wire         wr_ohi   = do_write && wr_idx == ccr_pkg::IDX_OCAL_HI;
   wire         wr_olo   = do_write && wr_idx == ccr_pkg::IDX_OCAL_LO;
   wire         wr_ghi   = do_write && wr_idx == ccr_pkg::IDX_GCAL_HI;
   wire         wr_glo   = do_write && wr_idx == ccr_pkg::IDX_GCAL_LO;

   // Read-only reserved bits of the config register stay zero
   wire [15:0]  next_cfg  = ((cfg & ~bmask) | (wr_data[15:0] & bmask))
                            & ccr_pkg::MASK_CFG;   // R11
   wire [15:0]  next_ohi  = (ch0_offset_cal_high & ~bmask)
                            | (wr_data[15:0] & bmask);
   wire [15:0]  next_ghi  = (ch0_gain_cal_high & ~bmask)
                            | (wr_data[15:0] & bmask);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_idx  <= 8'h00;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
      end else begin
         if (aw_take & ~do_write) begin
            aw_held <= 1'b1;
            aw_idx  <= s_axi_awaddr[9:2];
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
         if (w_take & ~do_write) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (do_write) begin
            w_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= ccr_pkg::RESP_OKAY;
      end else begin
         s_axi_awready <= ~have_aw & ~s_axi_bvalid & ~s_axi_awready;
         s_axi_wready  <= ~have_w & ~s_axi_bvalid & ~s_axi_wready;
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? ccr_pkg::RESP_OKAY
                                   : ccr_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ***************************************************************
   // Register update
   // ***************************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg                 <= ccr_pkg::RST_CFG;              // R10
         ch0_offset_cal_high <= ccr_pkg::RST_OCAL_HI;          // R5
         ch0_offset_cal_low  <= ccr_pkg::RST_OCAL_LO[15:8];    // R5
         ch0_gain_cal_high   <= ccr_pkg::RST_GCAL_HI;          // R9
         ch0_gain_cal_low    <= ccr_pkg::RST_GCAL_LO[15:8];    // R9
      end else begin
         if (wr_cfg) begin
            cfg <= next_cfg;                                   // R1
         end
         if (wr_ohi) begin
            ch0_offset_cal_high <= next_ohi;                   // R3
         end
         if (wr_olo && wr_strb[1]) begin
            ch0_offset_cal_low <= wr_data[15:8];               // R4
         end
         if (wr_ghi) begin
            ch0_gain_cal_high <= next_ghi;                     // R6
         end
         if (wr_glo && wr_strb[1]) begin
            ch0_gain_cal_low <= wr_data[15:8];                 // R7
         end
      end
   end

   // ***************************************************************
   // Read channel
   // ***************************************************************
   wire [7:0]   rd_idx = s_axi_araddr[9:2];
   wire         ar_take = s_axi_arvalid & s_axi_arready;
   wire         rd_hit  = (rd_idx >= ccr_pkg::IDX_CFG) &&
                          (rd_idx <= ccr_pkg::IDX_GCAL_LO);
   wire [15:0]  rd_val  =
      (rd_idx == ccr_pkg::IDX_CFG)     ? cfg :
      (rd_idx == ccr_pkg::IDX_OCAL_HI) ? ch0_offset_cal_high :         // R3
      (rd_idx == ccr_pkg::IDX_OCAL_LO) ? {ch0_offset_cal_low, 8'h00} : // R4
      (rd_idx == ccr_pkg::IDX_GCAL_HI) ? ch0_gain_cal_high :           // R6
      (rd_idx == ccr_pkg::IDX_GCAL_LO) ? {ch0_gain_cal_low, 8'h00} :   // R7
      16'h0000;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= ccr_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
         if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {16'h0000, rd_val};   // R11
            s_axi_rresp  <= rd_hit ? ccr_pkg::RESP_OKAY
                                   : ccr_pkg::RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ***************************************************************
   // Input routing
   // ***************************************************************
   wire [1:0] ch0_input_select = cfg[1:0];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ch0_route_inputs <= 1'b1;
         ch0_short_inputs <= 1'b0;
         ch0_test_pos     <= 1'b0;
         ch0_test_neg     <= 1'b0;
      end else begin
         ch0_route_inputs <= ch0_input_select == ccr_pkg::SEL_NORMAL;   // R1
         ch0_short_inputs <= ch0_input_select == ccr_pkg::SEL_SHORT;    // R1
         ch0_test_pos     <= ch0_input_select == ccr_pkg::SEL_TEST_POS; // R2
         ch0_test_neg     <= ch0_input_select == ccr_pkg::SEL_TEST_NEG; // R2
      end
   end

   // ***************************************************************
   // Calibration datapath
   // ***************************************************************
   wire signed [23:0] offset_val = {ch0_offset_cal_high,
                                    ch0_offset_cal_low};          // R5
   wire [23:0]        gain_val   = {ch0_gain_cal_high,
                                    ch0_gain_cal_low};            // R8
   wire signed [24:0] diff = $signed({raw_sample[23], raw_sample})
                             - $signed({offset_val[23], offset_val}); // R12
   // Gain has 23 fraction bits: 0x800000 is unity
   wire signed [49:0] prod = diff * $signed({1'b0, gain_val});   // R8
   wire signed [26:0] scaled = prod[49:23];
   wire               too_hi = scaled > 27'sh7F_FFFF;
   wire               too_lo = scaled < -27'sh80_0000;
   wire [23:0]        sat = too_hi ? 24'h7F_FFFF :
                            too_lo ? 24'h80_0000 : scaled[23:0];  // R12

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cal_sample <= 24'h00_0000;
         cal_valid  <= 1'b0;
      end else begin
         cal_valid <= raw_valid;
         if (raw_valid) begin
            cal_sample <= sat;                                    // R12
         end
      end
   end
endmodule : ccr_regs

// >>> tb/ccr_regs_props.sv
`timescale 1ns/1ps
// ***************************************************************
// Port checker for the channel 0 register group
// ***************************************************************
module ccr_regs_props (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // Register bus
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic [31:0] s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   // Datapath and front end
   input wire logic        raw_valid,
   input wire logic        cal_valid,
   input wire logic        ch0_route_inputs,
   input wire logic        ch0_short_inputs,
   input wire logic        ch0_test_pos,
   input wire logic        ch0_test_neg
);
   logic [7:0] rd_idx;
   wire  [3:0] hot = {ch0_test_neg, ch0_test_pos, ch0_short_inputs,
                      ch0_route_inputs};
   wire        rd_cfg = s_axi_rvalid && rd_idx == ccr_pkg::IDX_CFG;
   wire        rd_lo  = s_axi_rvalid && (rd_idx == ccr_pkg::IDX_OCAL_LO ||
                                         rd_idx == ccr_pkg::IDX_GCAL_LO);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Remembers which register the pending read targets
   always_ff @(posedge clk or posedge rst) begin
      if (rst) rd_idx <= 8'h00;
      else if (s_axi_arvalid && s_axi_arready) rd_idx <= s_axi_araddr[9:2];
   end
   sequence ar_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence w_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sel_onehot_a: assert property ($onehot(hot))
      else $error("selector decode not one-hot");
   sel_match_a: assert property (rd_cfg |->
                                 hot == 4'h1 << s_axi_rdata[1:0])
      else $error("selector decode disagrees with config");
   cfg_ro_zero_a: assert property (rd_cfg |-> s_axi_rdata[5:3] == 3'b000)
      else $error("config read-only bits not zero");
   lo_byte_zero_a: assert property (rd_lo |->
                                    s_axi_rdata[7:0] == 8'h00)
      else $error("lower register low byte not zero");
   rd_hi_zero_a: assert property (s_axi_rvalid |->
                                  !(|s_axi_rdata[31:16]))
      else $error("read data upper half not zero");
   cal_valid_a: assert property (cal_valid == $past(raw_valid))
      else $error("corrected sample strobe misaligned");
   rd_latency_a: assert property (ar_take |=> s_axi_rvalid)
      else $error("read answer late");
   wr_latency_a: assert property (w_take |=> s_axi_bvalid)
      else $error("write answer late");
   no_accept_a: assert property (s_axi_bvalid |->
                                 !s_axi_awready && !s_axi_wready)
      else $error("request taken while answer pending");
endmodule : ccr_regs_props

bind ccr_regs ccr_regs_props u_props (.clk, .rst, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .raw_valid,
   .cal_valid, .ch0_route_inputs, .ch0_short_inputs, .ch0_test_pos,
   .ch0_test_neg);

// >>> tb/ccr_regs_tb.sv
`timescale 1ns/1ps
// ***************************************************************
// Self-checking bench for the channel 0 register group
// ***************************************************************
module ccr_regs_tb;
   typedef struct {logic [31:0] a, d, e;
                   logic [3:0]  s;
                   logic [1:0]  r;} ccr_row_s;
   logic        clk = 1'b0, rst = 1'b1;
   logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, d;
   logic [3:0]  s_axi_wstrb = '0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1, raw_valid = 1'b0;
   logic [23:0] raw_sample = '0, cal_sample;
   logic [31:0] s_axi_rdata;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, cal_valid, ch0_route_inputs, ch0_short_inputs;
   logic        ch0_test_pos, ch0_test_neg;
   int          bad_count = 0, checked = 0;
   wire  [3:0]  hot = {ch0_test_neg, ch0_test_pos, ch0_short_inputs,
                       ch0_route_inputs};
   ccr_row_s rows [11] = '{
      '{32'h0000_0024, 32'h0000_003B, 32'h0000_0003, 4'hF, 2'h0},
      '{32'h0000_0024, 32'h0000_0001, 32'h0000_0001, 4'hF, 2'h0},
      '{32'h0000_0024, 32'h0000_0002, 32'h0000_0002, 4'hF, 2'h0},
      '{32'h0000_0024, 32'h0000_0003, 32'h0000_0003, 4'hF, 2'h0},
      '{32'h0000_0024, 32'h0000_0000, 32'h0000_0000, 4'hF, 2'h0},
      '{32'h0000_0028, 32'h0000_1234, 32'h0000_1234, 4'hF, 2'h0},
      '{32'h0000_002C, 32'h0000_ABCD, 32'h0000_AB00, 4'hF, 2'h0},
      '{32'h0000_002C, 32'h0000_77FF, 32'h0000_AB00, 4'h1, 2'h0},
      '{32'h0000_0030, 32'h0000_4000, 32'h0000_4000, 4'hF, 2'h0},
      '{32'h0000_0034, 32'h00FF_5A77, 32'h0000_5A00, 4'hF, 2'h0},
      '{32'h0000_0040, 32'h0000_1111, 32'h0000_0000, 4'hF, 2'h2}};

   ccr_regs uut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .raw_sample, .raw_valid, .cal_sample, .cal_valid, .ch0_route_inputs,
      .ch0_short_inputs, .ch0_test_pos, .ch0_test_neg);

   always #2.5 clk = ~clk;

   task automatic chk(input string n, input logic [31:0] e, g);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // Address and data offered together, each released once taken
   task automatic wr(input logic [31:0] a, v, input logic [3:0] s);
      @(posedge clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= v;
      s_axi_wstrb   <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while ((s_axi_awvalid && !s_axi_awready) ||
                 (s_axi_wvalid && !s_axi_wready));
      while (!s_axi_bvalid) @(posedge clk);
      rs = s_axi_bresp;
   endtask : wr

   task automatic rd(input logic [31:0] a);
      @(posedge clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      while (!s_axi_rvalid) @(posedge clk);
      d  = s_axi_rdata;
      rs = s_axi_rresp;
   endtask : rd

   task automatic smp(input logic [23:0] v, e);
      @(posedge clk);
      raw_sample <= v;
      raw_valid  <= 1'b1;
      @(posedge clk);
      raw_valid  <= 1'b0;
      @(posedge clk);
      chk("cal_valid", 32'h0000_0001, 32'(cal_valid));
      chk("cal_sample", 32'(e), 32'(cal_sample));
   endtask : smp

   task automatic print_verdict();
      $display("checked %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : print_verdict

   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      chk("decode reset", 32'h0000_0001, 32'(hot));
      for (int i = 0; i < 5; i++) begin
         rd(32'h0000_0024 + 32'(4 * i));
         chk("reset value", (i == 3) ? 32'h0000_8000 : '0, d);
      end
      $display("test reset values done");
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d, rows[i].s);
         chk("bresp", 32'(rows[i].r), 32'(rs));
         rd(rows[i].a);
         chk("rdata", rows[i].e, d);
         chk("rresp", 32'(rows[i].r), 32'(rs));
         if (rows[i].a == 32'h0000_0024)
            chk("decode", 32'(4'h1 << rows[i].e[1:0]), 32'(hot));
      end
      $display("test register table done");
      wr(32'h0000_0028, 32'h0000_FFFF, 4'hF);
      wr(32'h0000_002C, 32'h0000_FF00, 4'hF);
      wr(32'h0000_0030, 32'h0000_4000, 4'hF);
      wr(32'h0000_0034, 32'h0000_0000, 4'hF);
      smp(24'h00_0063, 24'h00_0032);
      wr(32'h0000_0030, 32'h0000_FFFF, 4'hF);
      wr(32'h0000_0034, 32'h0000_FF00, 4'hF);
      smp(24'h7F_FFFF, 24'h7F_FFFF);
      smp(24'h80_0000, 24'h80_0000);
      $display("test datapath done");
      wr(32'h0000_0024, 32'h0000_0002, 4'hF);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd(32'h0000_0030);
      chk("gain after reset", 32'h0000_8000, d);
      rd(32'h0000_0028);
      chk("offset after reset", 32'h0000_0000, d);
      rd(32'h0000_0024);
      chk("cfg after reset", 32'h0000_0000, d);
      chk("decode after reset", 32'h0000_0001, 32'(hot));
      $display("test second reset done");
      print_verdict();
   end

   initial begin
      #50000;
      bad_count++;
      print_verdict();
   end
endmodule : ccr_regs_tb
